// >>> core/adm_pkg.sv
// constants for the mode-control register pair of the audio converter
package adm_pkg;

  localparam int unsigned WORD_BITS = 16;
  localparam logic [4:0]  BIT_COUNT_FULL = 5'h10;

  // control word layout
  localparam int unsigned OP_BIT   = 15;
  localparam int unsigned INDEX_MSB = 14;
  localparam int unsigned INDEX_LSB = 8;
  localparam logic        OP_WRITE = 1'h0;
  localparam logic        OP_READ  = 1'h1;

  // register indices
  localparam logic [6:0] INDEX_FORMAT   = 7'h14;
  localparam logic [6:0] INDEX_READBACK = 7'h15;
  localparam logic [6:0] INDEX_LOWEST   = 7'h14;

  // format, clock and filter word fields
  localparam int unsigned INTERP_BIT  = 7;
  localparam int unsigned ROLL_MSB    = 6;
  localparam int unsigned ROLL_LSB    = 5;
  localparam int unsigned DIVIDE_BIT  = 4;
  localparam int unsigned DISABLE_BIT = 3;
  localparam int unsigned FORMAT_MSB  = 2;
  localparam int unsigned FORMAT_LSB  = 0;

  // read-back word fields
  localparam int unsigned INC_BIT   = 7;
  localparam int unsigned RIDX_MSB  = 6;
  localparam int unsigned RIDX_LSB  = 0;

  // reset values
  localparam logic [7:0] FORMAT_RESET   = 8'h00;
  localparam logic [7:0] READBACK_RESET = 8'h01;

  // format codes, 110 and 111 reserved
  localparam logic [2:0] FORMAT_RJ24 = 3'h0;
  localparam logic [2:0] FORMAT_RJ20 = 3'h1;
  localparam logic [2:0] FORMAT_RJ18 = 3'h2;
  localparam logic [2:0] FORMAT_RJ16 = 3'h3;
  localparam logic [2:0] FORMAT_I2S  = 3'h4;
  localparam logic [2:0] FORMAT_JUST = 3'h5;

  // roll-off codes
  localparam logic [1:0] ROLL_SHARP = 2'h0;
  localparam logic [1:0] ROLL_SLOW1 = 2'h1;
  localparam logic [1:0] ROLL_SLOW2 = 2'h2;

  // interpolation rate codes
  localparam logic INTERP_8X = 1'h0;
  localparam logic INTERP_4X = 1'h1;

  typedef enum logic {
    ADM_RD_IDLE,
    ADM_RD_ACTIVE
  } adm_rd_state_e;

endpackage : adm_pkg

// >>> core/adm_clkout.sv
// clock output pin generator: full or half rate, or released
`timescale 1ns/100ps
`default_nettype none

module adm_clkout
  import adm_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic disable_in,
  input  wire logic divide_in,
  output var  logic pin_out,
  output var  logic oe_out
);

  logic pin;
  logic oe;
  logic phase;
  logic next_pin;
  logic next_oe;
  logic next_phase;

  always_comb begin
    next_oe    = ~disable_in;                          // see [RULE2]
    next_phase = ~phase;
    next_pin   = pin;
    if (disable_in) begin
      next_pin   = 1'h0;                               // see [RULE3]
      next_phase = 1'h0;
    end else if (!divide_in || phase) begin
      next_pin = ~pin;                                 // see [RULE4] see [RULE5]
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin   <= 1'h0;
      oe    <= 1'h0;
      phase <= 1'h0;
    end else begin
      pin   <= next_pin;
      oe    <= next_oe;
      phase <= next_phase;
    end
  end

  assign pin_out = pin;
  assign oe_out  = oe;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence half_run_s;
    (!disable_in && divide_in)[*4];
  endsequence

  clk_full_rate_a : assert property (  // see [RULE4]
    @(posedge clk_in) disable iff (!rst_b_in)
    (!disable_in && !divide_in)[*2] |-> ##1 (pin_out != $past(pin_out)))
    else $error("clock output not toggling at full rate");

  clk_half_rate_a : assert property (  // see [RULE5]
    @(posedge clk_in) disable iff (!rst_b_in)
    half_run_s ##0 $rose(pin_out) |-> ##1 pin_out
      ##1 (!pin_out || $past(disable_in) || !$past(divide_in)))
    else $error("clock output not at half rate");

  clk_release_a : assert property (  // see [RULE3]
    @(posedge clk_in) disable iff (!rst_b_in)
    disable_in |=> (!oe_out && !pin_out))
    else $error("clock output driven while disabled");

endmodule : adm_clkout

`default_nettype wire

// >>> core/adm_mode_regs.sv
// mode-control register pair with its serial control port
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RULE1] three-bit format field selects audio format
// [RULE2] clock disable bit resets zero, output driven
// [RULE3] disabled clock output is released, not driven
// [RULE4] enabled clock output is full or half rate
// [RULE5] divide bit resets zero; one halves rate
// [RULE6] roll-off field: sharp, slow one, slow two
// [RULE7] host uses slow roll-off only at 8x
// [RULE8] rate bit resets to 8x; one selects 4x
// [RULE9] host keeps 8x up to 96 kHz
// [RULE10] top word bit: zero writes, one reads
// [RULE11] increment bit resets zero; one enables auto-read
// [RULE12] read index field resets to one
// [RULE13] auto-read stops after the read index
// [RULE14] read word: op, index, increment, read index
// [RULE15] format word: rate, roll-off, divide, disable, format
// [RULE16] auto-read starts at lowest register, steps one
module adm_mode_regs
  import adm_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       ctl_latch_b_in,
  input  wire logic       ctl_shift_in,
  input  wire logic       ctl_data_in,
  output var  logic       ctl_data_out,
  output var  logic [2:0] audio_format_select_out,
  output var  logic [1:0] rolloff_select_out,
  output var  logic       interp_rate_select_out,
  output var  logic       clock_output_pin_out,
  output var  logic       clock_output_pin_oe_out
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'h0;
      rst_sync <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_sync <= rst_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register contents as seen on read-back

  function automatic logic [7:0] reg_value(input logic [6:0] reg_num,
                                           input logic [7:0] format_word,
                                           input logic [7:0] rb_word);
    logic [7:0] val;
    val = 8'h00;
    if (reg_num == INDEX_FORMAT) begin
      val = format_word;
    end else if (reg_num == INDEX_READBACK) begin
      val = rb_word;
    end
    return val;
  endfunction : reg_value

  //////////////////////////////////////////////////////////////////////////////
  // control port and registers

  logic [7:0]          format_clock_filter_control;
  logic [7:0]          readback_index_control;
  logic [WORD_BITS-1:0] in_sr;
  logic [WORD_BITS-1:0] out_sr;
  logic [4:0]          bit_cnt;
  logic                prev_latch_b;
  logic                prev_shift;
  adm_rd_state_e       rd_state;
  logic [6:0]          rd_index;
  logic [6:0]          rd_last;
  logic                rd_auto;

  logic [7:0]          next_format_word;
  logic [7:0]          next_rb_word;
  logic [WORD_BITS-1:0] next_in_sr;
  logic [WORD_BITS-1:0] next_out_sr;
  logic [4:0]          next_bit_cnt;
  adm_rd_state_e       next_rd_state;
  logic [6:0]          next_rd_index;
  logic [6:0]          next_rd_last;
  logic                next_rd_auto;

  logic frame_start;
  logic frame_end;
  logic shift_rise;
  logic word_done;
  logic [6:0] cmd_index;

  assign frame_start = prev_latch_b && !ctl_latch_b_in;
  assign frame_end   = !prev_latch_b && ctl_latch_b_in;
  assign shift_rise  = !prev_shift && ctl_shift_in && !ctl_latch_b_in;
  assign word_done   = frame_end && (bit_cnt == BIT_COUNT_FULL);
  assign cmd_index   = in_sr[INDEX_MSB:INDEX_LSB];

  always_comb begin
    next_format_word = format_clock_filter_control;
    next_rb_word  = readback_index_control;
    next_in_sr    = in_sr;
    next_out_sr   = out_sr;
    next_bit_cnt  = bit_cnt;
    next_rd_state = rd_state;
    next_rd_index = rd_index;
    next_rd_last  = rd_last;
    next_rd_auto  = rd_auto;

    if (frame_start) begin
      next_bit_cnt = 5'h00;
      next_out_sr  = 16'h0000;
      if (rd_state == ADM_RD_ACTIVE) begin
        next_out_sr = {1'h0, rd_index,
                       reg_value(rd_index, format_clock_filter_control,
                                 readback_index_control)};  // see [RULE14]
      end
    end else if (shift_rise) begin
      next_in_sr  = {in_sr[WORD_BITS-2:0], ctl_data_in};
      next_out_sr = {out_sr[WORD_BITS-2:0], 1'h0};
      if (bit_cnt != BIT_COUNT_FULL) begin
        next_bit_cnt = bit_cnt + 5'h01;
      end
    end

    case (rd_state)
      ADM_RD_IDLE: begin
        if (word_done && in_sr[OP_BIT] == OP_WRITE) begin            // see [RULE10]
          if (cmd_index == INDEX_FORMAT) begin
            next_format_word = in_sr[7:0];                           // see [RULE15]
          end else if (cmd_index == INDEX_READBACK) begin
            next_rb_word = in_sr[7:0];                               // see [RULE14]
          end
        end else if (word_done && in_sr[OP_BIT] == OP_READ) begin    // see [RULE10]
          if (cmd_index == INDEX_READBACK) begin
            next_rb_word = in_sr[7:0];
          end
          next_rd_state = ADM_RD_ACTIVE;
          next_rd_auto  = next_rb_word[INC_BIT];                     // see [RULE11]
          next_rd_last  = next_rb_word[RIDX_MSB:RIDX_LSB];           // see [RULE13]
          next_rd_index = next_rb_word[INC_BIT] ? INDEX_LOWEST
                          : next_rb_word[RIDX_MSB:RIDX_LSB];         // see [RULE16] see [RULE12]
        end
      end
      ADM_RD_ACTIVE: begin
        if (word_done) begin
          if (rd_auto && rd_index < rd_last) begin
            next_rd_index = rd_index + 7'h01;                        // see [RULE16]
          end else begin
            next_rd_state = ADM_RD_IDLE;                             // see [RULE13]
          end
        end
      end
      default: begin
        next_rd_state = ADM_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      format_clock_filter_control <= FORMAT_RESET;     // see [RULE1] see [RULE2] see [RULE8]
      readback_index_control      <= READBACK_RESET;   // see [RULE11] see [RULE12]
      in_sr        <= 16'h0000;
      out_sr       <= 16'h0000;
      bit_cnt      <= 5'h00;
      prev_latch_b <= 1'h1;
      prev_shift   <= 1'h0;
      rd_state     <= ADM_RD_IDLE;
      rd_index     <= 7'h00;
      rd_last      <= 7'h00;
      rd_auto      <= 1'h0;
      ctl_data_out            <= 1'h0;
      audio_format_select_out <= FORMAT_RJ24;
      rolloff_select_out      <= ROLL_SHARP;
      interp_rate_select_out  <= INTERP_8X;
    end else begin
      format_clock_filter_control <= next_format_word;
      readback_index_control      <= next_rb_word;
      in_sr        <= next_in_sr;
      out_sr       <= next_out_sr;
      bit_cnt      <= next_bit_cnt;
      prev_latch_b <= ctl_latch_b_in;
      prev_shift   <= ctl_shift_in;
      rd_state     <= next_rd_state;
      rd_index     <= next_rd_index;
      rd_last      <= next_rd_last;
      rd_auto      <= next_rd_auto;
      // data out follows the shifter one cycle late so it comes from a flop
      ctl_data_out            <= out_sr[WORD_BITS-1];
      audio_format_select_out <= format_clock_filter_control[FORMAT_MSB:FORMAT_LSB]; // see [RULE1]
      rolloff_select_out      <= format_clock_filter_control[ROLL_MSB:ROLL_LSB]; // see [RULE6]
      interp_rate_select_out  <= format_clock_filter_control[INTERP_BIT];        // see [RULE8]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock output pin

  adm_clkout adm_clkout_inst (
    .clk_in     (clk_in),
    .rst_b_in   (rst_sync),
    .disable_in (format_clock_filter_control[DISABLE_BIT]),   // see [RULE2]
    .divide_in  (format_clock_filter_control[DIVIDE_BIT]),    // see [RULE5]
    .pin_out    (clock_output_pin_out),
    .oe_out     (clock_output_pin_oe_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence format_write_s;
    word_done && rd_state == ADM_RD_IDLE && !in_sr[OP_BIT] && cmd_index == INDEX_FORMAT;
  endsequence

  sequence read_cmd_s;
    word_done && rd_state == ADM_RD_IDLE && in_sr[OP_BIT];
  endsequence

  format_field_a : assert property (  // see [RULE1]
    @(posedge clk_in) disable iff (!rst_sync)
    format_write_s |-> ##2 (audio_format_select_out == $past(in_sr[2:0], 2)))
    else $error("format output does not follow written field");

  rolloff_field_a : assert property (  // see [RULE6]
    @(posedge clk_in) disable iff (!rst_sync)
    format_write_s |-> ##2 (rolloff_select_out == $past(in_sr[6:5], 2)))
    else $error("roll-off output does not follow written field");

  interp_field_a : assert property (  // see [RULE8]
    @(posedge clk_in) disable iff (!rst_sync)
    format_write_s |-> ##2 (interp_rate_select_out == $past(in_sr[7], 2)))
    else $error("rate output does not follow written bit");

  clk_disable_a : assert property (  // see [RULE2]
    @(posedge clk_in) disable iff (!rst_sync)
    format_write_s ##0 in_sr[3] |-> ##2 !clock_output_pin_oe_out)
    else $error("clock output still driven after disable write");

  read_start_a : assert property (  // see [RULE10]
    @(posedge clk_in) disable iff (!rst_sync)
    read_cmd_s |=> (rd_state == ADM_RD_ACTIVE))
    else $error("read command did not start read-back");

  auto_first_a : assert property (  // see [RULE16]
    @(posedge clk_in) disable iff (!rst_sync)
    read_cmd_s ##1 rd_auto |-> (rd_index == INDEX_LOWEST))
    else $error("auto read does not start at lowest register");

  auto_stop_a : assert property (  // see [RULE13]
    @(posedge clk_in) disable iff (!rst_sync)
    (word_done && rd_state == ADM_RD_ACTIVE && rd_index >= rd_last) |=> (rd_state == ADM_RD_IDLE))
    else $error("auto read ran past last index");

  read_word_a : assert property (  // see [RULE14]
    @(posedge clk_in) disable iff (!rst_sync)
    (frame_start && rd_state == ADM_RD_ACTIVE) |=> (out_sr[14:8] == $past(rd_index)))
    else $error("read-back word carries wrong index");

  write_ignore_a : assert property (  // see [RULE10]
    @(posedge clk_in) disable iff (!rst_sync)
    read_cmd_s ##0 (cmd_index == INDEX_FORMAT) |=> $stable(format_clock_filter_control))
    else $error("read command altered format word");

endmodule : adm_mode_regs

`default_nettype wire

// >>> testbench/adm_host_model.sv
// host side model driving the serial control port of the mode registers
`timescale 1ns/100ps
`default_nettype none

module adm_host_model (
  input  wire logic clk_in,
  input  wire logic rdata_in,
  output var  logic latch_b_out,
  output var  logic shift_out,
  output var  logic data_out
);
  initial begin
    latch_b_out = 1'h1;
    shift_out   = 1'h0;
    data_out    = 1'h0;
  end

  // one 16-bit frame msb first; r collects what the device shifts out
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    // frames always open just after a rising edge, whatever the caller waited on
    @(posedge clk_in);
    latch_b_out <= 1'h0;
    repeat (3) @(posedge clk_in);
    for (int i = 15; i >= 0; i--) begin
      data_out <= w[i];
      repeat (2) @(posedge clk_in);
      @(negedge clk_in) r[i] = rdata_in;
      @(posedge clk_in) shift_out <= 1'h1;
      repeat (2) @(posedge clk_in);
      shift_out <= 1'h0;
    end
    repeat (2) @(posedge clk_in);
    latch_b_out <= 1'h1;
    // released data line must not keep showing the last bit
    data_out    <= ~w[0];
    repeat (4) @(posedge clk_in);
  endtask : xfer
endmodule : adm_host_model

`default_nettype wire

// >>> testbench/audio_dac_mode_control_regs_test.sv
// self-checking bench for the mode-control register pair
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module audio_dac_mode_control_regs_test;
  import adm_pkg::*;

  logic       clk_in;
  logic       rst_b_in;
  logic       latch_b;
  logic       shift;
  logic       sdata;
  logic       rdata;
  logic [2:0] format_sel;
  logic [1:0] roll;
  logic       rate;
  logic       pin;
  logic       oe;
  wire        clk_pin_wire;
  int         err_count;
  int         n_tests;
  int         cycles;
  logic [15:0] rx;
  logic [7:0]  fw;
  int          n;

  assign clk_pin_wire = oe ? pin : 1'bz;

  adm_mode_regs adm_mode_regs_inst (
    .clk_in                  (clk_in),
    .rst_b_in                (rst_b_in),
    .ctl_latch_b_in          (latch_b),
    .ctl_shift_in            (shift),
    .ctl_data_in             (sdata),
    .ctl_data_out            (rdata),
    .audio_format_select_out (format_sel),
    .rolloff_select_out      (roll),
    .interp_rate_select_out  (rate),
    .clock_output_pin_out    (pin),
    .clock_output_pin_oe_out (oe)
  );

  adm_host_model adm_host_model_inst (
    .clk_in      (clk_in),
    .rdata_in    (rdata),
    .latch_b_out (latch_b),
    .shift_out   (shift),
    .data_out    (sdata)
  );

  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // a hang counts as a mismatch
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic wr(input logic [6:0] reg_num, input logic [7:0] d);
    adm_host_model_inst.xfer({OP_WRITE, reg_num, d}, rx);
  endtask : wr

  // read command, then one frame that carries the answer back
  task automatic rd(input logic [6:0] reg_num, input logic [7:0] d);
    adm_host_model_inst.xfer({OP_READ, reg_num, d}, rx);
    adm_host_model_inst.xfer(16'h0000, rx);
  endtask : rd

  task automatic toggles(output int cnt);
    logic last;
    cnt  = 0;
    last = pin;
    repeat (16) begin
      @(negedge clk_in);
      if (pin !== last) cnt++;
      last = pin;
    end
  endtask : toggles

  initial begin
    err_count = 0;
    n_tests   = 0;
    cycles    = 0;
    rst_b_in  = 1'h0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    `CHK("format reset", 3'h0, format_sel)
    `CHK("rolloff reset", 2'h0, roll)
    `CHK("rate reset", 1'h0, rate)
    `CHK("clock oe reset", 1'h1, oe)
    toggles(n);
    `CHK("full rate toggles", 16, n)
    rd(INDEX_FORMAT, 8'h00);
    `CHK("readback reset word", {1'h0, 7'h01, 8'h00}, rx)
    $display("test reset done");

    // host keeps slow roll-off at 8x only
    for (int i = 0; i < 8; i++) begin
      fw = {(i % 3 == 0 && i > 0) ? INTERP_4X : INTERP_8X, 2'(i % 3), 2'h0, 3'(i)};
      wr(INDEX_FORMAT, fw);
      `CHK("format code", fw[FORMAT_MSB:FORMAT_LSB], format_sel)
      `CHK("rolloff code", fw[ROLL_MSB:ROLL_LSB], roll)
      `CHK("rate code", fw[INTERP_BIT], rate)
    end
    wr(7'h13, 8'hff);
    `CHK("other index ignored", 3'h7, format_sel)
    $display("test format codes done");

    wr(INDEX_FORMAT, 8'h10);
    toggles(n);
    `CHK("half rate toggles", 8, n)
    wr(INDEX_FORMAT, 8'h08);
    repeat (2) @(posedge clk_in);
    `CHK("disabled oe", 1'h0, oe)
    `CHK("disabled pin released", 1'bz, clk_pin_wire)
    wr(INDEX_FORMAT, 8'h00);
    `CHK("re-enabled oe", 1'h1, oe)
    $display("test clock output done");

    // slow roll-off two stays at 8x
    wr(INDEX_FORMAT, 8'h45);
    wr(INDEX_READBACK, {1'h0, INDEX_FORMAT});
    rd(INDEX_FORMAT, 8'hff);
    `CHK("read word not written", 3'h5, format_sel)
    `CHK("single read word", {1'h0, INDEX_FORMAT, 8'h45}, rx)
    $display("test single read done");

    rd(INDEX_READBACK, 8'h95);
    `CHK("auto read first", {1'h0, INDEX_LOWEST, 8'h45}, rx)
    adm_host_model_inst.xfer(16'h0000, rx);
    `CHK("auto read second", {1'h0, INDEX_READBACK, 8'h95}, rx)
    wr(INDEX_FORMAT, 8'h23);
    `CHK("auto read stopped", 3'h3, format_sel)
    `CHK("rolloff after stop", 2'h1, roll)
    $display("test auto read done");
    final_report();
  end
endmodule : audio_dac_mode_control_regs_test

`undef CHK
`default_nettype wire
